// *** core/rcos_regs.svh ***
`ifndef RCOS_REGS_SVH
`define RCOS_REGS_SVH

// Byte addresses on the register bus.
`define RCOS_CTRL_ADDR 12'h018
`define RCOS_STAT_ADDR 12'h01c

// Control register field positions.
`define RCOS_EN_BIT 15
`define RCOS_SRC_HI 14
`define RCOS_SRC_LO 11
`define RCOS_FREQ_HI 10
`define RCOS_FREQ_LO 8
`define RCOS_SQ_HI 5
`define RCOS_SQ_LO 4
`define RCOS_KIND_HI 2
`define RCOS_KIND_LO 0

// Writable bits of the control register; reserved bits read as zero.
`define RCOS_CTRL_WMASK 16'hff37
`define RCOS_CTRL_RESET 16'h0000

// Status register bit positions.
`define RCOS_STAT_GATE_BIT 0
`define RCOS_STAT_PIN_BIT 1
`define RCOS_STAT_RSVD_BIT 2
`define RCOS_STAT_POLICY_BIT 3

// Highest legal codes of the coded fields.
`define RCOS_SRC_MAX 4'h3
`define RCOS_FREQ_MAX 3'h2
`define RCOS_KIND_MAX 3'h1

`endif

// *** core/rcos_pkg.sv ***
package rcos_pkg;

  typedef enum logic [1:0] {
    RCOS_SQ_AUTO,
    RCOS_SQ_AUTO_RELAXED,
    RCOS_SQ_LINK_ONLY,
    RCOS_SQ_OFF
  } rcos_squelch_e;

  typedef enum logic [2:0] {
    RCOS_FREQ_25M,
    RCOS_FREQ_125M,
    RCOS_FREQ_31M25
  } rcos_freq_e;

  typedef enum logic [2:0] {
    RCOS_KIND_SERIAL,
    RCOS_KIND_COPPER
  } rcos_kind_e;

  typedef enum logic [1:0] {
    RCOS_SPEED_10,
    RCOS_SPEED_100,
    RCOS_SPEED_1000
  } rcos_speed_e;

  typedef logic [15:0] rcos_ctrl_t;

endpackage : rcos_pkg

// *** core/rcos_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rcos_regs.svh"

// How it works
// - Output runs only while the enable bit is one; it resets to zero.
// - Four-bit source code picks port 0 to 3; higher codes are reserved.
// - Frequency code 0 is 25, 1 is 125, 2 is 31.25 MHz; rest reserved.
// - Level 00 holds low on down, unstable, 1000 master, 10, or EEE.
// - Level 01 acts as 00 but passes 1000 master and 10 link-up.
// - Level 01 keeps the clock during EEE while LP_IDLE is received.
// - Level 10 suppresses only while the link is not up.
// - Level 11 never suppresses, even with the link down.
// - A high squelch pin suppresses the output whatever the settings.
// - Kind code 0 picks serial media clock, 1 copper clock; rest reserved.
module rcos_top #(
  parameter int NUM_PORTS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [NUM_PORTS-1:0] rec_clk_serial,
  input wire logic [NUM_PORTS-1:0] rec_clk_copper,
  input wire logic [NUM_PORTS-1:0] link_up,
  input wire logic [NUM_PORTS-1:0] link_stable,
  input wire logic [2*NUM_PORTS-1:0] link_speed,
  input wire logic [NUM_PORTS-1:0] link_master,
  input wire logic [NUM_PORTS-1:0] eee_active,
  input wire logic [NUM_PORTS-1:0] lp_idle_rx,
  input wire logic clk_squelch_in,
  output logic recovered_clock_out_two,
  output logic clock_gate_open,
  output logic [1:0] src_port_sel,
  output rcos_pkg::rcos_kind_e clock_kind_sel,
  output rcos_pkg::rcos_freq_e freq_sel
);
  import rcos_pkg::*;

  // Refuse port counts that the two-bit source index cannot serve.
  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 4.");
  end

  // Returns one when the squelch policy lets the selected port's clock out.
  function automatic logic policy_pass(
    input rcos_squelch_e level,
    input logic up,
    input logic stable,
    input rcos_speed_e speed,
    input logic master,
    input logic eee,
    input logic lp_idle
  );
    logic no_recovery;
    no_recovery = (speed == RCOS_SPEED_10) ||
                  ((speed == RCOS_SPEED_1000) && master);
    unique case (level)
      RCOS_SQ_AUTO: begin
        policy_pass = up && stable && !no_recovery && !eee;
      end
      RCOS_SQ_AUTO_RELAXED: begin
        policy_pass = up && stable && (!eee || lp_idle);
      end
      RCOS_SQ_LINK_ONLY: begin
        policy_pass = up;
      end
      RCOS_SQ_OFF: begin
        policy_pass = 1'b1;
      end
    endcase
  endfunction : policy_pass

  // Returns one when any coded field of the control word is reserved.
  function automatic logic ctrl_reserved(input rcos_ctrl_t c);
    logic [3:0] src_code;
    src_code = c[`RCOS_SRC_HI:`RCOS_SRC_LO];
    ctrl_reserved = (src_code > `RCOS_SRC_MAX) ||
                    (src_code >= 4'(NUM_PORTS)) ||
                    (c[`RCOS_FREQ_HI:`RCOS_FREQ_LO] > `RCOS_FREQ_MAX) ||
                    (c[`RCOS_KIND_HI:`RCOS_KIND_LO] > `RCOS_KIND_MAX);
  endfunction : ctrl_reserved

  // Squelch pin synchroniser.
  logic pin_meta_reg;
  logic pin_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= clk_squelch_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Register bus slave state.
  rcos_ctrl_t ctrl_reg;
  rcos_ctrl_t ctrl_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [31:0] stat_word;
  logic setup_phase;
  logic access_done;
  logic addr_ctrl;
  logic addr_stat;
  logic gate_reg;
  logic rsvd_flag;
  logic policy_ok;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign addr_ctrl = (paddr == `RCOS_CTRL_ADDR);
  assign addr_stat = (paddr == `RCOS_STAT_ADDR);

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`RCOS_STAT_GATE_BIT] = gate_reg;
    stat_word[`RCOS_STAT_PIN_BIT] = pin_sync_reg;
    stat_word[`RCOS_STAT_RSVD_BIT] = rsvd_flag;
    stat_word[`RCOS_STAT_POLICY_BIT] = policy_ok;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (setup_phase) begin
      pready_next = 1'b1;
      pslverr_next = !(addr_ctrl || (addr_stat && !pwrite));
      if (!pwrite && addr_ctrl) begin
        prdata_next = {16'h0000, ctrl_reg};
      end else if (!pwrite && addr_stat) begin
        prdata_next = stat_word;
      end else begin
        prdata_next = 32'h0000_0000;
      end
    end
    if (access_done && pwrite && addr_ctrl) begin
      if (pstrb[0]) begin
        ctrl_next[7:0] = pwdata[7:0] & 8'h37;
      end
      if (pstrb[1]) begin
        ctrl_next[15:8] = pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RCOS_CTRL_RESET;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // Clock selection and squelch gating.
  logic [1:0] port_idx;
  logic sel_clk;
  logic gate_next;
  logic out_reg;
  logic out_next;
  logic [1:0] src_reg;
  logic [1:0] src_next;
  rcos_kind_e kind_reg;
  rcos_kind_e kind_next;
  rcos_freq_e freq_reg;
  rcos_freq_e freq_next;

  always_comb begin
    port_idx = ctrl_reg[`RCOS_SRC_LO+1:`RCOS_SRC_LO];
    rsvd_flag = ctrl_reserved(ctrl_reg);
    policy_ok = 1'b0;
    sel_clk = 1'b0;
    if (!rsvd_flag) begin
      policy_ok = policy_pass(
        rcos_squelch_e'(ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO]),
        link_up[port_idx],
        link_stable[port_idx],
        rcos_speed_e'(link_speed[2*port_idx +: 2]),
        link_master[port_idx],
        eee_active[port_idx],
        lp_idle_rx[port_idx]);
      if (ctrl_reg[`RCOS_KIND_LO]) begin
        sel_clk = rec_clk_copper[port_idx];
      end else begin
        sel_clk = rec_clk_serial[port_idx];
      end
    end
    gate_next = ctrl_reg[`RCOS_EN_BIT] && !pin_sync_reg &&
                !rsvd_flag && policy_ok;
    out_next = gate_next && sel_clk;
    src_next = rsvd_flag ? src_reg : port_idx;
    kind_next = rsvd_flag ? kind_reg : rcos_kind_e'(ctrl_reg[2:0]);
    freq_next = rsvd_flag ? freq_reg :
                rcos_freq_e'(ctrl_reg[`RCOS_FREQ_HI:`RCOS_FREQ_LO]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg <= 1'b0;
      out_reg <= 1'b0;
      src_reg <= 2'h0;
      kind_reg <= RCOS_KIND_SERIAL;
      freq_reg <= RCOS_FREQ_25M;
    end else begin
      gate_reg <= gate_next;
      out_reg <= out_next;
      src_reg <= src_next;
      kind_reg <= kind_next;
      freq_reg <= freq_next;
    end
  end

  assign recovered_clock_out_two = out_reg;
  assign clock_gate_open = gate_reg;
  assign src_port_sel = src_reg;
  assign clock_kind_sel = kind_reg;
  assign freq_sel = freq_reg;

  // Checks on the design's own outputs.
  sequence s_pin_high_2;
    pin_sync_reg ##1 pin_sync_reg;
  endsequence

  sequence s_enabled_auto_down;
    ctrl_reg[`RCOS_EN_BIT] &&
      ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h0 &&
      !rsvd_flag && !link_up[port_idx];
  endsequence

  a_enable_off_low: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[`RCOS_EN_BIT] |=> !gate_reg && !out_reg)
    else $error("Output open while disabled.");

  a_source_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg[`RCOS_SRC_HI:`RCOS_SRC_LO] > 4'h3) |=> !gate_reg)
    else $error("Gate open with reserved source.");

  a_freq_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg[`RCOS_FREQ_HI:`RCOS_FREQ_LO] > 3'h2) |=>
      !gate_reg && $stable(freq_sel))
    else $error("Reserved frequency passed through.");

  a_auto_link_down: assert property (@(posedge pclk) disable iff (!presetn)
    s_enabled_auto_down |=> !gate_reg)
    else $error("Level 00 passed a down link.");

  a_auto_ten_base: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h0 &&
      link_speed[2*port_idx +: 2] == 2'h0 |=> !gate_reg)
    else $error("Level 00 passed 10BASE-T.");

  a_relaxed_master: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`RCOS_EN_BIT] && !pin_sync_reg && !rsvd_flag &&
      ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h1 &&
      link_up[port_idx] && link_stable[port_idx] &&
      (!eee_active[port_idx] || lp_idle_rx[port_idx]) |=> gate_reg)
    else $error("Level 01 squelched a usable link.");

  a_link_only_up: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`RCOS_EN_BIT] && !pin_sync_reg && !rsvd_flag &&
      ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h2 |=>
      gate_reg == $past(link_up[port_idx]))
    else $error("Level 10 gate does not follow link.");

  a_squelch_off: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`RCOS_EN_BIT] && !pin_sync_reg && !rsvd_flag &&
      ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h3 |=> gate_reg)
    else $error("Level 11 squelched the output.");

  a_pin_squelch: assert property (@(posedge pclk) disable iff (!presetn)
    s_pin_high_2 |=> !gate_reg && !out_reg)
    else $error("Squelch pin did not hold output low.");

  a_kind_select: assert property (@(posedge pclk) disable iff (!presetn)
    gate_next && ctrl_reg[`RCOS_KIND_LO] |=>
      out_reg == $past(rec_clk_copper[port_idx]))
    else $error("Copper clock not routed.");

  a_kind_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg[`RCOS_KIND_HI:`RCOS_KIND_LO] > 3'h1) |=> ##[0:1] !out_reg)
    else $error("Reserved kind left output running.");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase |=> pready_reg ##1 !pready_reg)
    else $error("Ready not a single cycle after setup.");

  a_auto_eee_block: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h0 &&
      eee_active[port_idx] |=> !gate_reg)
    else $error("Level 00 passed a link in energy saving mode.");

  a_auto_master_block: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h0 &&
      link_speed[2*port_idx +: 2] == 2'h2 &&
      link_master[port_idx] |=> !gate_reg)
    else $error("Level 00 passed a gigabit master link.");

  a_relaxed_down: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[`RCOS_SQ_HI:`RCOS_SQ_LO] == 2'h1 &&
      !link_up[port_idx] |=> !gate_reg)
    else $error("Level 01 passed a down link.");

  a_kind_serial: assert property (@(posedge pclk) disable iff (!presetn)
    gate_next && !ctrl_reg[`RCOS_KIND_LO] |=>
      out_reg == $past(rec_clk_serial[port_idx]))
    else $error("Serial clock not routed.");

  a_out_needs_gate: assert property (@(posedge pclk) disable iff (!presetn)
    out_reg |-> gate_reg)
    else $error("Output high while the gate is shut.");

  a_source_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !rsvd_flag |=> src_port_sel == $past(port_idx))
    else $error("Source select does not follow the control word.");

  a_freq_follow: assert property (@(posedge pclk) disable iff (!presetn)
    !rsvd_flag |=>
      freq_sel == $past(ctrl_reg[`RCOS_FREQ_HI:`RCOS_FREQ_LO]))
    else $error("Frequency select does not follow the control word.");

  a_rsvd_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg & ~`RCOS_CTRL_WMASK) == 16'h0000)
    else $error("Reserved control bits were written.");

  a_bad_address: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !(addr_ctrl || (addr_stat && !pwrite)) |=> pslverr_reg)
    else $error("Unmapped access gave no error.");

endmodule : rcos_top
`default_nettype wire

// *** testbench/rcos_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcos_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic squelch_req,
  output logic [3:0] rec_clk_serial,
  output logic [3:0] rec_clk_copper,
  output logic clk_squelch_in
);
  logic [1:0] phase_reg;
  // Serial clocks toggle every cycle, copper clocks every second cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 2'h0;
      clk_squelch_in <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      clk_squelch_in <= squelch_req;
    end
  end
  assign rec_clk_serial = {4{phase_reg[0]}};
  assign rec_clk_copper = {4{phase_reg[1]}};
endmodule : rcos_far_model
`default_nettype wire

// *** testbench/rcos_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rcos_top_tb;
  import rcos_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, clock_gate_open, rco, sq_pin;
  logic sq_req = 1'b0;
  logic [3:0] strb = 4'h3;
  logic [3:0] rs, rc;
  logic [3:0] up = 4'h0, st = 4'h0, ms = 4'h0, ee = 4'h0, lp = 4'h0;
  logic [7:0] spd = 8'h00;
  logic [1:0] src_port_sel;
  rcos_kind_e clock_kind_sel;
  rcos_freq_e freq_sel;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #12.5 pclk = ~pclk;

  rcos_top rcos_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rec_clk_serial(rs), .rec_clk_copper(rc), .link_up(up),
    .link_stable(st), .link_speed(spd), .link_master(ms),
    .eee_active(ee), .lp_idle_rx(lp), .clk_squelch_in(sq_pin),
    .recovered_clock_out_two(rco), .clock_gate_open(clock_gate_open),
    .src_port_sel(src_port_sel), .clock_kind_sel(clock_kind_sel),
    .freq_sel(freq_sel));

  rcos_far_model rcos_far_model_i (.pclk(pclk), .presetn(presetn),
    .squelch_req(sq_req), .rec_clk_serial(rs), .rec_clk_copper(rc),
    .clk_squelch_in(sq_pin));

  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic apb(input bit w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected gate from the control word, selected port status and pin.
  function automatic bit exp_gate(int c, int u, int s, int sp, int m,
                                  int ev, int l, int pin);
    if (pin != 0 || c[15] == 0) return 1'b0;
    if (c[14:11] > 3 || c[10:8] > 2 || c[2:0] > 1) return 1'b0;
    case (c[5:4])
      2'h3: return 1'b1;
      2'h2: return u != 0;
      2'h1: return u && s && (!ev || l);
      default: return u && s && !ev && (sp == 1 || (sp == 2 && !m));
    endcase
  endfunction : exp_gate

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] r;
    logic e;
    logic b;
    int c, src, fr, kd, p, n;
    bit x, y, z, v;
    int ls, lf, lk;
    void'($urandom(32'h6e62));
    ls = 0;
    lf = 0;
    lk = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk(r === 32'h0 && clock_gate_open === 1'b0 && rco === 1'b0, "reset");
    apb(1'b0, 12'h01c, 32'h0, r, e);
    chk(r === 32'h0 && e === 1'b0, "status after reset");
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(e === 1'b1 && r === 32'h0, "unmapped read");
    apb(1'b1, 12'h01c, 32'hffff, r, e);
    chk(e === 1'b1, "status write");
    strb <= 4'h1;
    apb(1'b1, 12'h018, 32'hffff, r, e);
    strb <= 4'h2;
    apb(1'b1, 12'h018, 32'h1200, r, e);
    strb <= 4'h3;
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk(r === 32'h1237 && e === 1'b0, "byte strobes");
    $display("Test registers done");
    for (int t = 0; t < 80; t++) begin
      src = $urandom % 5;
      fr = $urandom % 4;
      kd = $urandom % 3;
      c = int'(($urandom % 4) != 0) << 15 | src << 11 | fr << 8;
      c = c | ($urandom % 4) << 4 | kd | ($urandom & 32'hc8);
      @(posedge pclk);
      up <= 4'($urandom);
      st <= 4'($urandom);
      ms <= 4'($urandom);
      ee <= 4'($urandom);
      lp <= 4'($urandom);
      spd <= {2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3),
              2'($urandom % 3)};
      sq_req <= ($urandom % 6) == 0;
      apb(1'b1, 12'h018, 32'(c), r, e);
      apb(1'b0, 12'h018, 32'h0, r, e);
      chk(r === (c & 32'hff37) && e === 1'b0, "control readback");
      repeat (6) @(posedge pclk);
      p = src % 4;
      x = exp_gate(c, up[p], st[p], spd[2*p +: 2], ms[p], ee[p], lp[p],
                   sq_req);
      chk(clock_gate_open === x, "gate");
      if (src < 4 && fr < 3 && kd < 2) begin
        ls = src;
        lf = fr;
        lk = kd;
      end
      y = src_port_sel === 2'(ls) && freq_sel === 3'(lf);
      y = y && clock_kind_sel === 3'(lk);
      chk(y, "field select");
      n = 0;
      for (int k = 0; k < 4; k++) begin
        b = rco;
        @(posedge pclk);
        n += int'(rco !== b);
      end
      y = x ? (kd != 0 ? n == 2 : n == 4) : (n == 0 && rco === 1'b0);
      chk(y, "clock output");
      z = exp_gate(c | 32'h8000, up[p], st[p], spd[2*p +: 2], ms[p], ee[p],
                   lp[p], 0);
      v = src > 3 || fr > 2 || kd > 1;
      apb(1'b0, 12'h01c, 32'h0, r, e);
      chk(r === {28'h0, z, v, sq_req, x} && e === 1'b0, "status");
    end
    $display("Test random done");
    end_of_test();
  end
endmodule : rcos_top_tb
`default_nettype wire
